// ---- design/fasi_pkg.sv ----
// fasi_pkg: register map, field positions, reset values and detector counts
// for the framer alarm status and interrupt block.
// assumes one 8-bit register port and one framer clock for the whole block.
package fasi_pkg;

  // register byte addresses
  localparam logic [7:0] FASI_LIVE_ADDR   = 8'h18;
  localparam logic [7:0] FASI_LATCH_ADDR  = 8'h19;
  localparam logic [7:0] FASI_IEN_ADDR    = 8'h1A;
  localparam logic [7:0] FASI_MASTER_ADDR = 8'h1C;

  // field positions, shared by live, latch and enable registers
  localparam int unsigned FASI_LOS_BIT    = 0;
  localparam int unsigned FASI_OOF_BIT    = 1;
  localparam int unsigned FASI_AIS_BIT    = 2;
  localparam int unsigned FASI_RAI_BIT    = 3;
  localparam int unsigned FASI_IDLE_BIT   = 4;
  localparam int unsigned FASI_SEF_BIT    = 5;
  localparam int unsigned FASI_ALIGN_BIT  = 7;
  localparam int unsigned FASI_MASTER_BIT = 0;

  // implemented bits; everything else reads as zero
  localparam logic [7:0] FASI_LIVE_MASK   = 8'h3F;
  localparam logic [7:0] FASI_LATCH_MASK  = 8'hBF;
  localparam logic [7:0] FASI_IEN_MASK    = 8'hBF;
  localparam logic [7:0] FASI_MASTER_MASK = 8'h01;

  // reset values
  localparam logic [7:0] FASI_LIVE_RESET   = 8'h00;
  localparam logic [7:0] FASI_LATCH_RESET  = 8'h00;
  localparam logic [7:0] FASI_IEN_RESET    = 8'h00;
  localparam logic [7:0] FASI_MASTER_RESET = 8'h00;

  // detector counts, in line bits, alignment words or framing bits
  localparam logic [7:0] FASI_LOS_ZERO_RUN   = 8'hC0;
  localparam logic [7:0] FASI_LOS_WINDOW     = 8'hC0;
  localparam logic [2:0] FASI_OOF_BAD_FAS    = 3'h4;
  localparam logic [2:0] FASI_OOF_GOOD_FAS   = 3'h3;
  localparam logic [4:0] FASI_SEF_ERR_LIMIT  = 5'h03;
  localparam int unsigned FASI_SEF_FBIT_WIN  = 16;
  localparam int unsigned FASI_ALIGN_W       = 13;

  // signal-absent detector states; code 2'b11 is illegal
  typedef enum logic [1:0] {
    FASI_LOS_CLEAR    = 2'b00,
    FASI_LOS_DECLARED = 2'b01,
    FASI_LOS_WINDOW_S = 2'b10
  } fasi_los_state_type;

  // one flag placed at a field position of an 8-bit register
  function automatic logic [7:0] fasi_place(input logic val, input int unsigned pos);
    return 8'(val) << pos;
  endfunction

  // number of errored framing bits in the sliding window
  function automatic logic [4:0] fasi_count_ones(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + 5'(v[i]);
    end
    return n;
  endfunction

endpackage

// ---- design/fasi_los_det.sv ----
// fasi_los_det: zero-run signal-absent detector on the dual-rail line stream.
// assumes i_bit_en pulses once per received line bit and i_exz_event is a
// one-cycle pulse from the line decoder.
`timescale 1ns/100ps
module fasi_los_det
  import fasi_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_bit_en,
  input  wire logic i_rx_bit,
  input  wire logic i_exz_event,
  output logic      o_signal_absent
);

  fasi_los_state_type state_reg;
  fasi_los_state_type state_next;
  logic [7:0]         zero_cnt_reg;
  logic [7:0]         zero_cnt_next;
  logic [7:0]         win_cnt_reg;
  logic [7:0]         win_cnt_next;

  // a one after declaration opens the clear window; any excess-zero event
  // inside it aborts the window and we wait for the next one
  always_comb begin
    state_next    = state_reg;
    zero_cnt_next = zero_cnt_reg;
    win_cnt_next  = win_cnt_reg;
    unique case (state_reg)
      FASI_LOS_CLEAR: begin
        if (i_bit_en) begin
          zero_cnt_next = i_rx_bit ? 8'h00 : zero_cnt_reg + 8'h01;
          if (!i_rx_bit && (zero_cnt_reg + 8'h01 == FASI_LOS_ZERO_RUN)) begin
            state_next = FASI_LOS_DECLARED; // [RQ15]
          end
        end
      end
      FASI_LOS_DECLARED: begin
        if (i_bit_en && i_rx_bit) begin
          state_next   = FASI_LOS_WINDOW_S; // [RQ15]
          win_cnt_next = 8'h01;
        end
      end
      FASI_LOS_WINDOW_S: begin
        if (i_exz_event) begin
          state_next = FASI_LOS_DECLARED; // [RQ15]
        end else if (i_bit_en) begin
          win_cnt_next = win_cnt_reg + 8'h01;
          if (win_cnt_reg + 8'h01 == FASI_LOS_WINDOW) begin
            state_next    = FASI_LOS_CLEAR; // [RQ15]
            zero_cnt_next = 8'h00;
          end
        end
      end
      default: begin
        state_next = FASI_LOS_DECLARED; // illegal code: assume the worst
      end
    endcase
  end

  // state and output flop
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg       <= FASI_LOS_CLEAR;
      zero_cnt_reg    <= 8'h00;
      win_cnt_reg     <= 8'h00;
      o_signal_absent <= 1'h0;
    end else begin
      state_reg       <= state_next;
      zero_cnt_reg    <= zero_cnt_next;
      win_cnt_reg     <= win_cnt_next;
      o_signal_absent <= (state_next != FASI_LOS_CLEAR);
    end
  end

  a_los_zero_run: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ15]
    (state_reg == FASI_LOS_CLEAR && i_bit_en && !i_rx_bit && zero_cnt_reg == 8'hBF)
    |=> o_signal_absent)
    else $error("signal absent not declared after zero run");

  a_los_exz_abort: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ15]
    (state_reg == FASI_LOS_WINDOW_S && i_exz_event)
    |=> (state_reg == FASI_LOS_DECLARED) && o_signal_absent)
    else $error("excess zero event did not abort clear window");

endmodule

// ---- design/fasi_top.sv ----
// fasi_top: live alarm status, change latches and interrupt for one framer.
// assumes the framer delivers its detector results as levels or one-cycle
// strobes on i_clock, and the host port is a plain strobe bus.
// Behaviour
// RQ1: live signal-absent bit at status bit 0
// RQ2: signal-absent valid only in dual-rail mode
// RQ3: live frame-sync-lost bit at status bit 1
// RQ4: live alarm-indication bit at status bit 2
// RQ5: live remote-alarm bit 3, overhead bits only
// RQ6: live idle-pattern bit 4, ignore in E3
// RQ7: live severe-frame-error bit at status bit 5
// RQ8: latch bits 0-5 set on any change
// RQ9: latch bit clears only on host write-one
// RQ10: interrupt needs latch, bit enable, master enable
// RQ11: interrupt drops when any term clears
// RQ12: alignment-change latch on resync at new alignment
// RQ13: alignment latch rearms only after lost sync
// RQ14: enable register mirrors latch bit positions
// RQ15: DS3 signal-absent after 192 zeros, window clear
// RQ16: E3 sync lost four bad, three good
// RQ17: DS3 severe error, three of sixteen F-bits
// RQ18: set beats simultaneous write-one clear
`timescale 1ns/100ps
module fasi_top
  import fasi_pkg::*;
(
  input  wire logic                              i_clock,
  input  wire logic                              i_rst,
  input  wire logic [7:0]                        i_addr,
  input  wire logic [7:0]                        i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic      [7:0]                        o_rdata,
  output logic                                   o_irq,
  input  wire logic                              i_e3_mode,
  input  wire logic                              i_dual_rail,
  input  wire logic                              i_line_bit_en,
  input  wire logic                              i_line_bit,
  input  wire logic                              i_excess_zero_event,
  input  wire logic                              i_ext_signal_absent,
  input  wire logic                              i_ds3_frame_sync_lost,
  input  wire logic                              i_fas_strobe,
  input  wire logic                              i_fas_good,
  input  wire logic                              i_fbit_strobe,
  input  wire logic                              i_fbit_error,
  input  wire logic                              i_alarm_indication,
  input  wire logic                              i_remote_alarm,
  input  wire logic                              i_idle_pattern_seen,
  input  wire logic [fasi_pkg::FASI_ALIGN_W-1:0] i_align_pos
);

  logic [7:0]              live_reg;
  logic [7:0]              live_next;
  logic [7:0]              latch_reg;
  logic [7:0]              latch_next;
  logic [7:0]              ien_reg;
  logic [7:0]              master_reg;
  logic [7:0]              rdata_reg;
  logic [2:0]              bad_cnt_reg;
  logic [2:0]              good_cnt_reg;
  logic                    e3_oof_reg;
  logic [15:0]             fbit_hist_reg;
  logic                    ds3_sef_reg;
  logic                    had_sync_reg;
  logic [FASI_ALIGN_W-1:0] held_align_reg;
  logic                    los_det;
  logic                    los_src;
  logic                    oof_src;
  logic                    sef_src;
  logic [15:0]             fbit_hist_next;
  logic [4:0]              fbit_err_cnt;
  logic                    sync_regain;
  logic                    alignment_change_event;
  logic [7:0]              set_vec;
  logic [7:0]              clr_vec;
  logic                    wr_latch;
  logic                    wr_ien;
  logic                    wr_master;
  logic [7:0]              rd_mux;

  // zero-run detector on the raw dual-rail stream
  fasi_los_det fasi_los_det_inst (
    .i_clock         (i_clock),
    .i_rst           (i_rst),
    .i_bit_en        (i_line_bit_en),
    .i_rx_bit        (i_line_bit),
    .i_exz_event     (i_excess_zero_event),
    .o_signal_absent (los_det)
  );

  // in binary mode the line interface has already decoded substitutions, so
  // long zero runs are legal traffic and its own indication is used instead
  assign los_src = i_dual_rail ? los_det : i_ext_signal_absent; // [RQ1] [RQ2]

  // E3 alignment word counters; DS3 sync state comes from the framer itself
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bad_cnt_reg  <= 3'h0;
      good_cnt_reg <= 3'h0;
      e3_oof_reg   <= 1'h0;
    end else if (i_fas_strobe && i_e3_mode) begin
      if (i_fas_good) begin
        bad_cnt_reg  <= 3'h0;
        good_cnt_reg <= (good_cnt_reg + 3'h1 == FASI_OOF_GOOD_FAS) ? 3'h0 : good_cnt_reg + 3'h1;
        if (e3_oof_reg && (good_cnt_reg + 3'h1 == FASI_OOF_GOOD_FAS)) begin
          e3_oof_reg <= 1'h0; // [RQ16]
        end
      end else begin
        good_cnt_reg <= 3'h0;
        bad_cnt_reg  <= (bad_cnt_reg + 3'h1 == FASI_OOF_BAD_FAS) ? 3'h0 : bad_cnt_reg + 3'h1;
        if (bad_cnt_reg + 3'h1 == FASI_OOF_BAD_FAS) begin
          e3_oof_reg <= 1'h1; // [RQ16]
        end
      end
    end
  end

  assign oof_src = i_e3_mode ? e3_oof_reg : i_ds3_frame_sync_lost; // [RQ3]

  // sliding window of the last sixteen DS3 framing bits
  assign fbit_hist_next = {fbit_hist_reg[FASI_SEF_FBIT_WIN-2:0], i_fbit_error};
  assign fbit_err_cnt   = fasi_count_ones(fbit_hist_next);

  // severe error clears only once back in sync, so it can outlast the errors
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fbit_hist_reg <= 16'h0000;
      ds3_sef_reg   <= 1'h0;
    end else if (i_fbit_strobe) begin
      fbit_hist_reg <= fbit_hist_next;
      if (fbit_err_cnt >= FASI_SEF_ERR_LIMIT) begin
        ds3_sef_reg <= 1'h1; // [RQ17]
      end else if (!oof_src) begin
        ds3_sef_reg <= 1'h0; // [RQ17]
      end
    end
  end

  // in E3 the severe error flag is the sync-lost flag itself
  assign sef_src = i_e3_mode ? e3_oof_reg : ds3_sef_reg; // [RQ16] [RQ7]

  // live status word; the idle bit is passed through in E3 and software
  // ignores it there, remote alarm input excludes far-end alarm codes
  assign live_next = fasi_place(los_src, FASI_LOS_BIT)
                   | fasi_place(oof_src, FASI_OOF_BIT)             // [RQ3]
                   | fasi_place(i_alarm_indication, FASI_AIS_BIT)  // [RQ4]
                   | fasi_place(i_remote_alarm, FASI_RAI_BIT)      // [RQ5]
                   | fasi_place(i_idle_pattern_seen, FASI_IDLE_BIT) // [RQ6]
                   | fasi_place(sef_src, FASI_SEF_BIT);            // [RQ7]

  // sync is regained on the falling edge of the live sync-lost bit
  assign sync_regain = live_reg[FASI_OOF_BIT] && !live_next[FASI_OOF_BIT];
  // no alignment is held before the first sync, so no change is reported then
  assign alignment_change_event  = sync_regain && had_sync_reg && (i_align_pos != held_align_reg); // [RQ12] [RQ13]

  // remember the alignment of every sync; a new event needs a new loss first
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      had_sync_reg   <= 1'h0;
      held_align_reg <= '0;
    end else if (sync_regain) begin
      had_sync_reg   <= 1'h1; // [RQ13]
      held_align_reg <= i_align_pos;
    end
  end

  // host write decode
  assign wr_latch  = i_wr && (i_addr == FASI_LATCH_ADDR);
  assign wr_ien    = i_wr && (i_addr == FASI_IEN_ADDR);
  assign wr_master = i_wr && (i_addr == FASI_MASTER_ADDR);

  // change latches: both edges of each live bit, plus alignment change;
  // set is applied after clear so an event in the clear cycle survives
  assign set_vec    = ((live_next ^ live_reg) & FASI_LIVE_MASK)    // [RQ8]
                    | fasi_place(alignment_change_event, FASI_ALIGN_BIT);      // [RQ12]
  assign clr_vec    = wr_latch ? (i_wdata & FASI_LATCH_MASK) : 8'h00; // [RQ9]
  assign latch_next = (latch_reg & ~clr_vec) | set_vec;            // [RQ18]

  // status and latch registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      live_reg  <= FASI_LIVE_RESET;
      latch_reg <= FASI_LATCH_RESET;
    end else begin
      live_reg  <= live_next;
      latch_reg <= latch_next;
    end
  end

  // enable registers; unused bits are stored as zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ien_reg    <= FASI_IEN_RESET;
      master_reg <= FASI_MASTER_RESET;
    end else begin
      if (wr_ien) begin
        ien_reg <= i_wdata & FASI_IEN_MASK; // [RQ14]
      end
      if (wr_master) begin
        master_reg <= i_wdata & FASI_MASTER_MASK;
      end
    end
  end

  // interrupt is pure gating of registers, so it falls in the same cycle
  // that any of its three terms is cleared
  assign o_irq = master_reg[FASI_MASTER_BIT] && |(latch_reg & ien_reg); // [RQ10] [RQ11]

  // read select; unmapped addresses read zero
  assign rd_mux = (i_addr == FASI_LIVE_ADDR)   ? live_reg   :
                  (i_addr == FASI_LATCH_ADDR)  ? latch_reg  :
                  (i_addr == FASI_IEN_ADDR)    ? ien_reg    :
                  (i_addr == FASI_MASTER_ADDR) ? master_reg : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_reg;

  a_live_los_dual: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ1]
    (i_dual_rail && !$past(i_rst)) |=> live_reg[FASI_LOS_BIT] == $past(los_det))
    else $error("live signal-absent bit does not follow detector");

  a_live_los_binary: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ2]
    (!i_dual_rail) |=> live_reg[FASI_LOS_BIT] == $past(i_ext_signal_absent))
    else $error("binary mode signal-absent not taken from line interface");

  a_live_alarm_bits: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ4]
    1'h1 |=> (live_reg[FASI_AIS_BIT] == $past(i_alarm_indication))
          && (live_reg[FASI_RAI_BIT] == $past(i_remote_alarm))
          && (live_reg[FASI_IDLE_BIT] == $past(i_idle_pattern_seen)))
    else $error("live alarm bits do not follow inputs");

  a_oof_four_bad: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ16]
    (i_e3_mode && i_fas_strobe && !i_fas_good && bad_cnt_reg == 3'h3)
    |=> e3_oof_reg ##1 live_reg[FASI_OOF_BIT] && live_reg[FASI_SEF_BIT])
    else $error("sync lost not declared on fourth bad alignment word");

  a_oof_three_good: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ16]
    (i_e3_mode && e3_oof_reg && i_fas_strobe && i_fas_good && good_cnt_reg == 3'h2)
    |=> !e3_oof_reg)
    else $error("sync lost not cleared on third good alignment word");

  a_sef_ds3_limit: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ17]
    (!i_e3_mode && i_fbit_strobe && fbit_err_cnt >= 5'h03) |=> ##1 live_reg[FASI_SEF_BIT])
    else $error("severe frame error missed with three errored F-bits");

  a_latch_on_change: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ8]
    ((live_next ^ live_reg) != 8'h00)
    |=> (latch_reg & $past((live_next ^ live_reg) & FASI_LIVE_MASK))
        == $past((live_next ^ live_reg) & FASI_LIVE_MASK))
    else $error("live bit change not latched");

  a_w1c_clears: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ9]
    (wr_latch && set_vec == 8'h00) |=> (latch_reg & $past(i_wdata)) == 8'h00)
    else $error("write one did not clear latch bit");

  a_w0_keeps: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ9]
    (!wr_latch) |=> (latch_reg & $past(latch_reg)) == $past(latch_reg))
    else $error("latch bit lost without write one");

  a_set_wins: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ18]
    (wr_latch && (set_vec & i_wdata) != 8'h00)
    |=> (latch_reg & $past(set_vec)) == $past(set_vec))
    else $error("event lost against simultaneous clear");

  a_irq_asserts: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ10]
    (wr_master && i_wdata[FASI_MASTER_BIT] && (latch_next & ien_reg) != 8'h00 && !wr_ien)
    |=> o_irq)
    else $error("interrupt missing with latch, enable and master set");

  a_irq_master_off: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ11]
    (wr_master && !i_wdata[FASI_MASTER_BIT]) |=> !o_irq [*2] or wr_master)
    else $error("interrupt stayed after master enable cleared");

  a_irq_ien_off: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ11]
    (wr_ien && i_wdata == 8'h00) |=> !o_irq)
    else $error("interrupt stayed after all bit enables cleared");

  a_alignment_change_latched: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ12]
    (alignment_change_event) |=> latch_reg[FASI_ALIGN_BIT] && had_sync_reg)
    else $error("alignment change not latched");

endmodule

// ---- test/fasi_host_model.sv ----
// fasi_host_model: host processor side of the alarm register port.
// assumes the plain strobe bus of fasi_top: one-cycle strobes, read data in the
// cycle after the read strobe, and no wait states from the device.
`timescale 1ns/100ps
module fasi_host_model
  import fasi_pkg::*;
(
  input  wire logic       i_clock,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  // bus idles with no strobe; address and data hold no meaning yet
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // one-cycle write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // one-cycle read; data is taken in the single cycle where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clock);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask

  // latch bits are cleared only by writing ones at their positions
  task automatic clear_latch(input logic [7:0] bits);
    wr(FASI_LATCH_ADDR, bits);
  endtask

  // enable bits sit at the same positions as the latch bits
  task automatic set_enables(input logic [7:0] bits);
    wr(FASI_IEN_ADDR, bits);
  endtask
endmodule

// ---- test/fasi_top_tb.sv ----
// fasi_top_tb: self-checking bench for the framer alarm status block.
// assumes the host model drives the register port and the bench plays the
// framer's detectors; all stimulus changes by non-blocking assignment on edges.
`timescale 1ns/100ps
module fasi_top_tb;
  import fasi_pkg::*;
  logic                    i_clock, i_rst, wr, rd, irq;
  logic [7:0]              addr, wdata, rdata;
  logic                    e3_mode, dual_rail, bit_en, line_bit, excess_zero_event, ext_los, ds3_oof;
  logic                    fas_stb, fas_good, fbit_stb, fbit_err, alarm_indication, remote_alarm, idle;
  logic [FASI_ALIGN_W-1:0] align_pos;
  int                      bad_count, samples_checked, cycles;

  fasi_top fasi_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_e3_mode(e3_mode),
    .i_dual_rail(dual_rail), .i_line_bit_en(bit_en), .i_line_bit(line_bit),
    .i_excess_zero_event(excess_zero_event), .i_ext_signal_absent(ext_los), .i_ds3_frame_sync_lost(ds3_oof),
    .i_fas_strobe(fas_stb), .i_fas_good(fas_good), .i_fbit_strobe(fbit_stb),
    .i_fbit_error(fbit_err), .i_alarm_indication(alarm_indication), .i_remote_alarm(remote_alarm),
    .i_idle_pattern_seen(idle), .i_align_pos(align_pos));
  fasi_host_model fasi_host_model_inst (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

  // 200 MHz framer clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard: the whole run needs about fifteen hundred cycles
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    fasi_host_model_inst.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    fasi_host_model_inst.rd(a, d);
    chk(what, exp, d);
  endtask
  // interrupt is looked at once the write edge has landed
  task automatic ichk(input logic exp);
    #1 chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  // detector stand-ins: level conditions and strobed words, bits and line bits
  task automatic set_cond(input int i, input logic b);
    @(posedge i_clock);
    case (i)
      0: ext_los <= b;
      1: ds3_oof <= b;
      2: alarm_indication <= b;
      3: remote_alarm <= b;
      default: idle <= b;
    endcase
  endtask
  task automatic frame_alignment_word(input int n, input logic g);
    repeat (n) begin
      @(posedge i_clock);
      fas_stb  <= 1'b1;
      fas_good <= g;
      @(posedge i_clock);
      fas_stb  <= 1'b0;
    end
  endtask
  task automatic fbit(input int n, input logic e);
    repeat (n) begin
      @(posedge i_clock);
      fbit_stb <= 1'b1;
      fbit_err <= e;
      @(posedge i_clock);
      fbit_stb <= 1'b0;
    end
  endtask
  task automatic lbits(input int n, input logic b);
    repeat (n) begin
      @(posedge i_clock);
      bit_en   <= 1'b1;
      line_bit <= b;
      @(posedge i_clock);
      bit_en   <= 1'b0;
    end
  endtask

  task automatic t_reset;
    rchk(FASI_LIVE_ADDR, 8'h00, "live reset");
    rchk(FASI_LATCH_ADDR, 8'h00, "latch reset");
    rchk(FASI_IEN_ADDR, 8'h00, "enable reset");
    rchk(FASI_MASTER_ADDR, 8'h00, "master reset");
    wreg(FASI_LIVE_ADDR, 8'hFF);
    rchk(FASI_LIVE_ADDR, 8'h00, "live read only");
    rchk(8'h20, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  // each level condition rises and falls; both edges must latch (binary line mode)
  task automatic t_live;
    logic [7:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 8'h01 << i;
      set_cond(i, 1'b1);
      tick(3);
      rchk(FASI_LIVE_ADDR, m, "live set");
      rchk(FASI_LATCH_ADDR, m, "latch rise");
      wreg(FASI_LATCH_ADDR, 8'h00);
      rchk(FASI_LATCH_ADDR, m, "latch zero write");
      wreg(FASI_LATCH_ADDR, m);
      rchk(FASI_LATCH_ADDR, 8'h00, "latch one write");
      set_cond(i, 1'b0);
      tick(3);
      rchk(FASI_LIVE_ADDR, 8'h00, "live clear");
      rchk(FASI_LATCH_ADDR, m, "latch fall");
      wreg(FASI_LATCH_ADDR, m);
    end
    $display("test live done");
  endtask

  task automatic t_irq;
    fasi_host_model_inst.set_enables(8'hFF);
    rchk(FASI_IEN_ADDR, 8'hBF, "enable bits");
    set_cond(2, 1'b1);
    tick(3);
    ichk(1'b0);
    wreg(FASI_MASTER_ADDR, 8'h01);
    ichk(1'b1);
    wreg(FASI_IEN_ADDR, 8'hFB);
    ichk(1'b0);
    wreg(FASI_IEN_ADDR, 8'hBF);
    ichk(1'b1);
    wreg(FASI_MASTER_ADDR, 8'h00);
    ichk(1'b0);
    wreg(FASI_MASTER_ADDR, 8'h01);
    fasi_host_model_inst.clear_latch(8'h04);
    ichk(1'b0);
    // the condition ends at the edge that raises the write strobe, so the
    // change and the clear are sampled at one edge
    fork
      wreg(FASI_LATCH_ADDR, 8'h04);
      begin
        @(posedge i_clock);
        alarm_indication <= 1'b0;
      end
    join
    rchk(FASI_LATCH_ADDR, 8'h04, "set beats clear");
    ichk(1'b1);
    wreg(FASI_IEN_ADDR, 8'h00);
    ichk(1'b0);
    wreg(FASI_LATCH_ADDR, 8'h04);
    wreg(FASI_MASTER_ADDR, 8'h00);
    $display("test irq done");
  endtask

  // alignment word counts, then resync at a new and at the same alignment
  task automatic t_e3;
    @(posedge i_clock);
    e3_mode   <= 1'b1;
    align_pos <= 13'h0005;
    frame_alignment_word(3, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "three bad words");
    frame_alignment_word(1, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h22, "four bad words");
    wreg(FASI_LATCH_ADDR, 8'h22);
    frame_alignment_word(2, 1'b1);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h22, "two good words");
    frame_alignment_word(1, 1'b1);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "three good words");
    rchk(FASI_LATCH_ADDR, 8'hA2, "new alignment");
    wreg(FASI_LATCH_ADDR, 8'hA2);
    frame_alignment_word(4, 1'b0);
    frame_alignment_word(3, 1'b1);
    tick(3);
    rchk(FASI_LATCH_ADDR, 8'h22, "same alignment");
    wreg(FASI_LATCH_ADDR, 8'h22);
    $display("test e3 done");
  endtask

  // three errored framing bits in sixteen; cleared once the first slides out
  task automatic t_sef;
    @(posedge i_clock);
    e3_mode <= 1'b0;
    fbit(2, 1'b1);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "two errored");
    fbit(1, 1'b1);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h20, "three errored");
    fbit(13, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h20, "window full");
    fbit(1, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "window clear");
    wreg(FASI_LATCH_ADDR, 8'h20);
    $display("test sef done");
  endtask

  // dual-rail zero run and the clearing window that opens at the first one
  task automatic t_los;
    @(posedge i_clock);
    dual_rail <= 1'b1;
    lbits(191, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "191 zeros");
    lbits(1, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h01, "192 zeros");
    // an excess-zero event aborts the window; without the abort 191 zeros would clear it
    lbits(1, 1'b1);
    @(posedge i_clock);
    excess_zero_event <= 1'b1;
    @(posedge i_clock);
    excess_zero_event <= 1'b0;
    lbits(191, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h01, "window aborted");
    lbits(1, 1'b1);
    lbits(190, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h01, "window open");
    lbits(1, 1'b0);
    tick(3);
    rchk(FASI_LIVE_ADDR, 8'h00, "window done");
    $display("test los done");
  endtask

  // all inputs defined at time zero; reset held for ten cycles
  initial begin
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    i_rst = 1'b1;
    {e3_mode, dual_rail, bit_en, line_bit, excess_zero_event, ext_los, ds3_oof} = 7'h00;
    {fas_stb, fas_good, fbit_stb, fbit_err, alarm_indication, remote_alarm, idle} = 7'h00;
    align_pos = '0;
    tick(10);
    i_rst <= 1'b0;
    t_reset();
    t_live();
    t_irq();
    t_e3();
    t_sef();
    t_los();
    conclude();
  end
endmodule
